// ---- common/dmcr_pkg.sv ----
// Purpose: constants and types for the dac mode-control register bank
// Assumes: 16-bit control words, registers indexed 16 to 22
// Notes:   reset values and most field positions live here; format bits 6..4, 1, 0 and output/filter bits 7..5 are coded in the bank
package dmcr_pkg;
  localparam logic [6:0] DMCR_IDX_LEFT  = 7'h10;
  localparam logic [6:0] DMCR_IDX_RIGHT = 7'h11;
  localparam logic [6:0] DMCR_IDX_FMT   = 7'h12;
  localparam logic [6:0] DMCR_IDX_OUTF  = 7'h13;
  localparam logic [6:0] DMCR_IDX_MODE  = 7'h14;
  localparam logic [6:0] DMCR_IDX_ZOUT  = 7'h15;
  localparam logic [6:0] DMCR_IDX_ZDET  = 7'h16;

  localparam int DMCR_POS_RW   = 15;
  localparam int DMCR_POS_IDXH = 14;
  localparam int DMCR_POS_IDXL = 8;

  // format register
  localparam int DMCR_POS_LOAD = 7;
  localparam int DMCR_POS_DMF  = 2;
  // output/filter register
  localparam int DMCR_POS_ODIS = 4;
  localparam int DMCR_POS_ZPIN = 3;
  localparam int DMCR_POS_BSTE = 2;
  localparam int DMCR_POS_ROLL = 1;
  localparam int DMCR_POS_INZM = 0;
  // operating mode register
  localparam int DMCR_POS_SOFT_SYSTEM_RESET = 6;
  localparam int DMCR_POS_BSEN = 5;
  localparam int DMCR_POS_BYP  = 4;
  localparam int DMCR_POS_MONO = 3;
  localparam int DMCR_POS_MSRC = 2;
  localparam int DMCR_POS_OSR  = 0;
  // zero output register
  localparam int DMCR_POS_PCM_ZERO_OUT_ENABLE = 0;
  localparam int DMCR_POS_BSZ  = 1;

  localparam logic [7:0] DMCR_MASK_MODE = 8'h7f;
  localparam logic [7:0] DMCR_MASK_ZOUT = 8'h07;
  localparam logic [7:0] DMCR_MASK_ZDET = 8'h03;

  localparam logic [7:0] DMCR_RST_LEVEL = 8'hff;
  localparam logic [7:0] DMCR_RST_FMT   = 8'h50;
  localparam logic [7:0] DMCR_RST_OUTF  = 8'h00;
  localparam logic [7:0] DMCR_RST_MODE  = 8'h00;
  localparam logic [7:0] DMCR_RST_ZOUT  = 8'h01;

  typedef struct packed {
    logic [7:0] left_q;
    logic [7:0] right_q;
    logic [7:0] left_act_q;
    logic [7:0] right_act_q;
    logic [7:0] fmt_q;
    logic [7:0] outf_q;
    logic [7:0] mode_q;
    logic [7:0] zout_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic [1:0] zf_l_q;
    logic [1:0] zf_r_q;
    logic       tgl_s1_q;
    logic       tgl_s2_q;
    logic       tgl_s3_q;
  } dmcr_state_t;

  typedef struct packed {
    logic        tgl_q;
    logic [15:0] word_q;
    logic [15:0] shift_q;
    logic [3:0]  cnt_q;
  } dmcr_link_t;
endpackage

// ---- core/dmcr_bank.sv ----
// Purpose: mode-control register bank of a stereo dac behind a serial control port
// Assumes: link side delivers msb-first 16-bit words framed by link_frame
// Notes:   words cross into clk by a ready level, data by hold-until-next-word
// How it works
// - bit 15 one reads, zero writes
// - zero-detect register ignores every write
// - bits 14..8 index, 7..0 data
// - output disable bit forces analog outputs off
// - zero-flag bit turns bitstream pins into outputs
// - bypass stereo select, monaural default
// - rolloff select, sharp by default
// - infinite zero mute enable, off default
// - soft reset bit commands system reset
// - bitstream enable and filter bypass bits
// - mono select and mono source channel
// - oversampling rate field, x64 default
// - bitstream mode reuses rate field for fir rate
// - bitstream mode reuses deemphasis field for fir
// - pcm zero output enable, on default
// - bitstream zero output enable field, off default
// - zero flags report left bit0, right bit1
// - level load clear keeps previous levels
`timescale 1ns/1ps
module dmcr_bank
  import dmcr_pkg::*;
(
  input  wire logic       clk,                // system clock
  input  wire logic       reset,              // synchronous reset, active high
  input  wire logic       link_clk,           // serial link clock
  input  wire logic       link_frame,         // high while a word is being shifted
  input  wire logic       link_data,          // serial data, msb first
  input  wire logic       zero_det_left,      // left zero-data detect (async)
  input  wire logic       zero_det_right,     // right zero-data detect (async)
  output logic [7:0]      read_data,          // data of the last read request
  output logic            read_valid,         // one-cycle pulse with read_data
  output logic [7:0]      left_level,         // active left attenuation level
  output logic [7:0]      right_level,        // active right attenuation level
  output logic [2:0]      data_format,        // audio data format
  output logic            deemph_enable,      // de-emphasis enable
  output logic            soft_mute,          // soft mute
  output logic [1:0]      deemphasis_rate_field, // de-emphasis rate (pcm)
  output logic [1:0]      fir_performance,    // analog fir performance (bitstream)
  output logic            phase_reverse,      // output phase reversal
  output logic [1:0]      atten_speed,        // attenuation step rate
  output logic            output_disable,     // analog outputs forced to zero
  output logic            zero_flag_pin_select, // bitstream pins drive zero flags
  output logic            bitstream_pin_oe_n, // low while bitstream pins are driven
  output logic [1:0]      bitstream_pin_out,  // zero flags on bitstream pins
  output logic            bypass_stereo_select, // bypass mode stereo
  output logic            rolloff_select,     // slow rolloff
  output logic            infinite_zero_mute_enable, // infinite zero mute
  output logic            soft_system_reset,  // system reset command
  output logic            bitstream_mode_enable, // one-bit stream mode
  output logic            filter_bypass_select, // internal filter bypassed
  output logic            mono_enable,        // monaural output
  output logic            mono_source_select, // right channel feeds mono
  output logic [1:0]      oversampling_rate_field, // delta-sigma rate (pcm/bypass)
  output logic [1:0]      fir_rate,           // analog fir rate (bitstream)
  output logic            pcm_zero_out_enable, // pcm zero output
  output logic [1:0]      bitstream_zero_out_enable // bitstream zero output
);

  // ----------------------------------------------------------------
  // link domain: shift in words, publish each by a ready level
  // ----------------------------------------------------------------
  dmcr_link_t ls_q;
  dmcr_link_t ls_d;

  // the word register is held until the next word completes, so clk
  // side samples it only after the ready level has crossed two flops
  // the link side has no reset: the ready level is rebuilt on every
  // link edge, so the first idle edge makes it defined; a toggle would
  // stay unknown forever
  // when the link clock stops after a word the level simply stays high
  // until the first link clock edge of the next word, which the clk side sees as one rise
  always_comb begin
    ls_d       = ls_q;
    ls_d.tgl_q = 1'b0;
    if (link_frame) begin
      ls_d.shift_q = {ls_q.shift_q[14:0], link_data};
      ls_d.cnt_q   = ls_q.cnt_q + 4'h1;
      if (ls_q.cnt_q == 4'hf) begin
        ls_d.word_q = {ls_q.shift_q[14:0], link_data};
        ls_d.tgl_q  = 1'b1;
      end
    end else begin
      ls_d.cnt_q = 4'h0;
    end
  end

  always_ff @(posedge link_clk) begin
    ls_q <= ls_d;
  end

  // ----------------------------------------------------------------
  // system domain: register bank
  // ----------------------------------------------------------------
  dmcr_state_t s_q;
  dmcr_state_t s_d;

  // ----------------------------------------------------------------
  // word decode
  // ----------------------------------------------------------------
  logic       word_evt;
  logic       rd_evt;
  logic       wr_evt;
  logic       is_read;
  logic [6:0] idx;
  logic [7:0] wdat;
  logic [7:0] zdet;
  logic       we_left;
  logic       we_right;
  logic       we_fmt;
  logic       we_outf;
  logic       we_mode;
  logic       we_zout;
  logic [7:0] rd_mux;

  // a new word is the rising edge of the synchronised ready level
  assign word_evt = s_q.tgl_s2_q & ~s_q.tgl_s3_q;
  // the word register is stable here: it only moves at the next
  // completion, which cannot come before this event is taken
  assign is_read  = ls_q.word_q[DMCR_POS_RW];
  assign idx      = ls_q.word_q[DMCR_POS_IDXH:DMCR_POS_IDXL];
  assign wdat     = ls_q.word_q[7:0];
  assign zdet     = {6'h00, s_q.zf_r_q[1], s_q.zf_l_q[1]};

  assign rd_evt   = word_evt & is_read;
  assign wr_evt   = word_evt & ~is_read;

  // write strobes, one per writable register
  // the zero-detect index and unknown indexes get no strobe at all
  always_comb begin
    we_left  = 1'b0;
    we_right = 1'b0;
    we_fmt   = 1'b0;
    we_outf  = 1'b0;
    we_mode  = 1'b0;
    we_zout  = 1'b0;
    if (!wr_evt) begin
      we_left = 1'b0;
    end else if (idx == DMCR_IDX_LEFT) begin
      we_left = 1'b1;
    end else if (idx == DMCR_IDX_RIGHT) begin
      we_right = 1'b1;
    end else if (idx == DMCR_IDX_FMT) begin
      we_fmt = 1'b1;
    end else if (idx == DMCR_IDX_OUTF) begin
      we_outf = 1'b1;
    end else if (idx == DMCR_IDX_MODE) begin
      we_mode = 1'b1;
    end else if (idx == DMCR_IDX_ZOUT) begin
      we_zout = 1'b1;
    end else if (idx == DMCR_IDX_ZDET) begin
      we_left = 1'b0;
    end
  end

  // read multiplexer; stored levels are returned, not the active ones
  always_comb begin
    rd_mux = 8'h00;
    if (idx == DMCR_IDX_LEFT) begin
      rd_mux = s_q.left_q;
    end else if (idx == DMCR_IDX_RIGHT) begin
      rd_mux = s_q.right_q;
    end else if (idx == DMCR_IDX_FMT) begin
      rd_mux = s_q.fmt_q;
    end else if (idx == DMCR_IDX_OUTF) begin
      rd_mux = s_q.outf_q;
    end else if (idx == DMCR_IDX_MODE) begin
      rd_mux = s_q.mode_q;
    end else if (idx == DMCR_IDX_ZOUT) begin
      rd_mux = s_q.zout_q;
    end else if (idx == DMCR_IDX_ZDET) begin
      rd_mux = zdet;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.rvalid_q = rd_evt;
    // ready level and zero flags each pass two flops before use
    s_d.tgl_s1_q = ls_q.tgl_q;
    s_d.tgl_s2_q = s_q.tgl_s1_q;
    s_d.tgl_s3_q = s_q.tgl_s2_q;
    s_d.zf_l_q   = {s_q.zf_l_q[0], zero_det_left};
    s_d.zf_r_q   = {s_q.zf_r_q[0], zero_det_right};

    // levels take effect only with load enabled
    if (s_q.fmt_q[DMCR_POS_LOAD]) begin
      s_d.left_act_q  = s_q.left_q;
      s_d.right_act_q = s_q.right_q;
    end

    if (rd_evt) begin
      s_d.rdata_q = rd_mux;
    end

    if (we_left) begin
      s_d.left_q = wdat;
    end
    if (we_right) begin
      s_d.right_q = wdat;
    end
    if (we_fmt) begin
      s_d.fmt_q = wdat;
    end
    if (we_outf) begin
      s_d.outf_q = wdat;
    end
    // reserved positions are cut at the write, so reads give zero
    if (we_mode) begin
      s_d.mode_q = wdat & DMCR_MASK_MODE;
    end
    if (we_zout) begin
      s_d.zout_q = wdat & DMCR_MASK_ZOUT;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q             <= '0;
      s_q.left_q      <= DMCR_RST_LEVEL;
      s_q.right_q     <= DMCR_RST_LEVEL;
      s_q.left_act_q  <= DMCR_RST_LEVEL;
      s_q.right_act_q <= DMCR_RST_LEVEL;
      s_q.fmt_q       <= DMCR_RST_FMT;
      s_q.outf_q      <= DMCR_RST_OUTF;
      s_q.mode_q      <= DMCR_RST_MODE;
      s_q.zout_q      <= DMCR_RST_ZOUT;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic bs_mode;
  logic byp_mode;

  assign bs_mode  = s_q.mode_q[DMCR_POS_BSEN];
  assign byp_mode = s_q.mode_q[DMCR_POS_BYP];

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  assign read_data  = s_q.rdata_q;
  assign read_valid = s_q.rvalid_q;

  // ----------------------------------------------------------------
  // attenuation and format
  // ----------------------------------------------------------------
  // the active levels, not the stored ones, reach the attenuators
  assign left_level    = s_q.left_act_q;
  assign right_level   = s_q.right_act_q;
  assign data_format   = s_q.fmt_q[6:4];
  assign deemph_enable = s_q.fmt_q[1];
  assign soft_mute     = s_q.fmt_q[0];

  // in bitstream mode the de-emphasis field steers the fir instead;
  // the unused port is held at zero so no consumer sees a stale mode
  always_comb begin
    deemphasis_rate_field = 2'b00;
    fir_performance       = 2'b00;
    if (bs_mode) begin
      fir_performance = s_q.fmt_q[DMCR_POS_DMF +: 2];
    end else begin
      deemphasis_rate_field = s_q.fmt_q[DMCR_POS_DMF +: 2];
    end
  end

  // ----------------------------------------------------------------
  // output and filter control
  // ----------------------------------------------------------------
  assign phase_reverse  = s_q.outf_q[7];
  assign atten_speed    = s_q.outf_q[6:5];
  // acts in every mode: pcm, bitstream and filter bypass alike
  assign output_disable = s_q.outf_q[DMCR_POS_ODIS];

  // the pins stay inputs until the select bit is set
  assign zero_flag_pin_select = s_q.outf_q[DMCR_POS_ZPIN];
  assign bitstream_pin_oe_n   = ~s_q.outf_q[DMCR_POS_ZPIN];
  assign bitstream_pin_out    = {s_q.zf_r_q[1], s_q.zf_l_q[1]};

  // stereo select matters only while the filter is bypassed
  assign bypass_stereo_select =
    s_q.outf_q[DMCR_POS_BSTE] & byp_mode;
  assign rolloff_select = s_q.outf_q[DMCR_POS_ROLL];
  assign infinite_zero_mute_enable = s_q.outf_q[DMCR_POS_INZM];

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  // the reset command is a plain level; whoever consumes it must
  // clear it by a write, the bank does not self-clear
  assign soft_system_reset     = s_q.mode_q[DMCR_POS_SOFT_SYSTEM_RESET];
  assign bitstream_mode_enable = bs_mode;
  assign filter_bypass_select  = byp_mode;
  assign mono_enable           = s_q.mode_q[DMCR_POS_MONO];
  assign mono_source_select    = s_q.mode_q[DMCR_POS_MSRC];

  // the rate field is shared: oversampling rate, or fir rate in
  // bitstream mode
  always_comb begin
    oversampling_rate_field = 2'b00;
    fir_rate                = 2'b00;
    if (bs_mode) begin
      fir_rate = s_q.mode_q[DMCR_POS_OSR +: 2];
    end else begin
      oversampling_rate_field = s_q.mode_q[DMCR_POS_OSR +: 2];
    end
  end

  // ----------------------------------------------------------------
  // zero outputs
  // ----------------------------------------------------------------
  assign pcm_zero_out_enable       = s_q.zout_q[DMCR_POS_PCM_ZERO_OUT_ENABLE];
  assign bitstream_zero_out_enable = s_q.zout_q[DMCR_POS_BSZ +: 2];

endmodule

// ---- sim/dmcr_chk.sv ----
// Purpose: port assertions for the mode-control bank
// Assumes: one clock domain, synchronous reset
// Notes:   bound to the bank from the bench top file
`timescale 1ns/1ps
module dmcr_chk
  import dmcr_pkg::*;
(
  input wire logic       clk,                     // clock
  input wire logic       reset,                   // reset
  input wire logic       read_valid,              // pulse
  input wire logic [7:0] read_data,               // read value
  input wire logic [7:0] left_level,              // level
  input wire logic       pcm_zero_out_enable,     // field
  input wire logic       zero_flag_pin_select,    // field
  input wire logic       bitstream_pin_oe_n,      // pin enable
  input wire logic       bypass_stereo_select,    // field
  input wire logic       filter_bypass_select,    // field
  input wire logic       bitstream_mode_enable,   // field
  input wire logic [1:0] oversampling_rate_field, // field
  input wire logic [1:0] deemphasis_rate_field,   // field
  input wire logic [1:0] fir_rate,                // field
  input wire logic [1:0] fir_performance,         // field
  input wire logic       zero_det_left,           // detect in
  input wire logic [1:0] bitstream_pin_out        // pin out
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // flag has to pass both sync flops before it is judged
  sequence s_left_zero_held; zero_det_left [*4]; endsequence
  property p_zflag; s_left_zero_held |-> bitstream_pin_out[0]; endproperty
  a_zflag: assert property (p_zflag) else $error("left zero flag missing");
  property p_oe; bitstream_pin_oe_n == !zero_flag_pin_select; endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_bste; bypass_stereo_select |-> filter_bypass_select; endproperty
  a_bste: assert property (p_bste) else $error("stereo outside bypass");
  property p_bs; bitstream_mode_enable |-> {oversampling_rate_field, deemphasis_rate_field} == 4'h0; endproperty
  a_bs: assert property (p_bs) else $error("pcm fields live in bitstream");
  property p_pcm; !bitstream_mode_enable |-> {fir_rate, fir_performance} == 4'h0; endproperty
  a_pcm: assert property (p_pcm) else $error("fir fields live in pcm");
  property p_rv; read_valid |=> !read_valid; endproperty
  a_rv: assert property (p_rv) else $error("read pulse too long");
  property p_rd; $changed(read_data) |-> read_valid; endproperty
  a_rd: assert property (p_rd) else $error("read data moved without read");
  property p_rst; $fell(reset) |-> left_level == 8'hff && pcm_zero_out_enable; endproperty
  a_rst: assert property (p_rst) else $error("reset defaults wrong");
endmodule

// ---- sim/dmcr_host.sv ----
// Purpose: host controller model on the serial control link
// Assumes: 48 ns link clock, stopped outside words after one idle edge
// Notes:   idle data line shows the inverse of the last bit
`timescale 1ns/1ps
module dmcr_host (
  output logic link_clk,   // runs within words and for one idle edge at start
  output logic link_frame, // high across 16 rising edges
  output logic link_data   // msb first
);
  initial begin
    link_clk = 1'b0;
    link_frame = 1'b0;
    link_data = 1'b0;
    // one idle edge so the link side settles before the first word
    #30 link_clk = 1'b1;
    #24 link_clk = 1'b0;
  end
  task automatic send(input logic [15:0] w);
    #5 link_frame = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      link_data = w[i];
      #24 link_clk = 1'b1;
      #24 link_clk = 1'b0;
    end
    link_frame = 1'b0;
    link_data = ~w[0];
  endtask
endmodule

// ---- sim/tb_dac_mode_control_registers.sv ----
// Purpose: self-checking bench for the mode-control bank
// Assumes: host model shifts every word, checker bound below
// Notes:   random fields from an xorshift seeded with 37
`timescale 1ns/1ps
module tb_dac_mode_control_registers import dmcr_pkg::*;;
  logic       clk, reset, link_clk, link_frame, link_data, zero_det_left, zero_det_right;
  logic [7:0] read_data, left_level, right_level;
  logic       read_valid, deemph_enable, soft_mute, phase_reverse, output_disable;
  logic       zero_flag_pin_select, bitstream_pin_oe_n, bypass_stereo_select, rolloff_select;
  logic       infinite_zero_mute_enable, soft_system_reset, bitstream_mode_enable;
  logic       filter_bypass_select, mono_enable, mono_source_select, pcm_zero_out_enable;
  logic [2:0] data_format;
  logic [1:0] deemphasis_rate_field, fir_performance, atten_speed, bitstream_pin_out;
  logic [1:0] oversampling_rate_field, fir_rate, bitstream_zero_out_enable;
  logic [31:0] rs = 32'h25;
  logic [7:0] rv [7] = '{8'hff, 8'hff, 8'h50, 8'h00, 8'h00, 8'h01, 8'h00};
  int         n_mismatch = 0;
  int         samples_checked = 0;
  dmcr_bank DUT (.clk, .reset, .link_clk, .link_frame, .link_data, .zero_det_left,
    .zero_det_right, .read_data, .read_valid, .left_level, .right_level, .data_format,
    .deemph_enable, .soft_mute, .deemphasis_rate_field, .fir_performance, .phase_reverse,
    .atten_speed, .output_disable, .zero_flag_pin_select, .bitstream_pin_oe_n,
    .bitstream_pin_out, .bypass_stereo_select, .rolloff_select, .infinite_zero_mute_enable,
    .soft_system_reset, .bitstream_mode_enable, .filter_bypass_select, .mono_enable,
    .mono_source_select, .oversampling_rate_field, .fir_rate, .pcm_zero_out_enable,
    .bitstream_zero_out_enable);
  dmcr_host host (.link_clk, .link_frame, .link_data);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic logic [21:0] pexp(input logic [7:0] f, o, m, z);
    return {o[4], o[3], o[2] & m[4], o[1], o[0], ~o[3], m[6:2],
            m[5] ? 2'h0 : m[1:0], m[5] ? m[1:0] : 2'h0,
            m[5] ? 2'h0 : f[3:2], m[5] ? f[3:2] : 2'h0, z[0], z[2:1]};
  endfunction
  task automatic chk(input logic [21:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    host.send({1'b0, i, d});
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    int k;
    fork
      host.send({1'b1, i, 8'h00});
      for (k = 0; k < 300 && read_valid !== 1'b1; k++) @(posedge clk) #1;
    join
    chk(22'(k < 300), 22'h1);
    chk(22'(read_data), 22'(e));
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #150000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    logic [7:0] f, o, m, z;
    reset = 1'b1;
    zero_det_left = 1'b0;
    zero_det_right = 1'b0;
    repeat (10) @(posedge clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 7; i++) rd(DMCR_IDX_LEFT + 7'(i), rv[i]);
    for (int i = 0; i < 6; i++) begin
      rs = xs(rs);
      {f, o, m, z} = i == 0 ? 32'hffffffff : i == 1 ? 32'h0 : rs;
      wr(DMCR_IDX_FMT, f);
      wr(DMCR_IDX_OUTF, o);
      wr(DMCR_IDX_MODE, m);
      wr(DMCR_IDX_ZOUT, z);
      chk({output_disable, zero_flag_pin_select, bypass_stereo_select, rolloff_select,
           infinite_zero_mute_enable, bitstream_pin_oe_n, soft_system_reset,
           bitstream_mode_enable, filter_bypass_select, mono_enable, mono_source_select,
           oversampling_rate_field, fir_rate, deemphasis_rate_field, fir_performance,
           pcm_zero_out_enable, bitstream_zero_out_enable}, pexp(f, o, m, z));
      rd(DMCR_IDX_MODE, m & 8'h7f);
      rd(DMCR_IDX_ZOUT, z & 8'h07);
      rd(DMCR_IDX_OUTF, o);
      #1 zero_det_left = rs[12];
      zero_det_right = rs[21];
      wr(DMCR_IDX_ZDET, 8'hff);
      chk(22'(bitstream_pin_out), 22'({rs[21], rs[12]}));
      rd(DMCR_IDX_ZDET, {6'h0, rs[21], rs[12]});
    end
    wr(DMCR_IDX_FMT, 8'h50);
    wr(DMCR_IDX_LEFT, 8'h3c);
    wr(DMCR_IDX_RIGHT, 8'hc3);
    chk(22'({left_level, right_level}), 22'h00ffff);
    rd(DMCR_IDX_LEFT, 8'h3c);
    wr(DMCR_IDX_FMT, 8'hd0);
    chk(22'({left_level, right_level}), 22'h003cc3);
    rd(7'h17, 8'h00);
    rd(7'h00, 8'h00);
    report_and_stop();
  end
endmodule
bind dmcr_bank dmcr_chk u_chk (.clk, .reset, .read_valid, .read_data, .left_level,
  .pcm_zero_out_enable, .zero_flag_pin_select, .bitstream_pin_oe_n, .bypass_stereo_select,
  .filter_bypass_select, .bitstream_mode_enable, .oversampling_rate_field,
  .deemphasis_rate_field, .fir_rate, .fir_performance, .zero_det_left, .bitstream_pin_out);
